// file: trace_pkg.sv
// Shared types and constants of the program trace element generator
package trace_pkg;

	localparam int ADDR_W = 32;
	localparam int CTX_W  = 32;
	localparam int EXC_W  = 8;
	localparam int CNT_W  = 8;

	localparam logic [CNT_W-1:0] CNT_ZERO  = 8'h00;
	localparam logic [CNT_W-1:0] CNT_ONE   = 8'h01;
	localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;

	// Core event operations
	typedef enum logic [2:0]
	{
		OP_NONE,
		OP_START,
		OP_PLAIN,
		OP_BRANCH,
		OP_EXCEPTION,
		OP_CANCEL,
		OP_COMMIT
	} core_op_t;

	// Trace element kinds
	typedef enum logic [2:0]
	{
		EK_INFO,
		EK_TRACE_ON,
		EK_CONTEXT,
		EK_ADDRESS,
		EK_ATOM,
		EK_EXCEPTION,
		EK_CANCEL,
		EK_COMMIT
	} elem_kind_t;

	typedef struct packed
	{
		core_op_t          op;
		logic              taken;
		logic [EXC_W-1:0]  exc_type;
		logic [ADDR_W-1:0] addr;
		logic [CTX_W-1:0]  ctx;
		logic [CNT_W-1:0]  count;
	} core_event_t;

	typedef struct packed
	{
		elem_kind_t        kind;
		logic              taken;
		logic [EXC_W-1:0]  exc_type;
		logic [ADDR_W-1:0] addr;
		logic [CNT_W-1:0]  count;
	} trace_elem_t;

endpackage : trace_pkg

// file: pending_count.sv
// Counter of emitted but unresolved instruction-bearing elements
`timescale 1ns/100ps
module pending_count #(
	parameter int CW = trace_pkg::CNT_W
) (
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          clear_i,
	input  wire logic          inc_i,
	input  wire logic [CW-1:0] dec_i,
	output logic      [CW-1:0] count_o
);

	logic [CW-1:0] count_reg;
	logic [CW-1:0] count_next;
	logic          at_max;

	assign at_max     = (count_reg == {CW{1'b1}});
	assign count_next = clear_i ? trace_pkg::CNT_RESET
		: count_reg + CW'(inc_i && !at_max) - dec_i;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			count_reg <= trace_pkg::CNT_RESET;
		else
			count_reg <= count_next;
	end

	assign count_o = count_reg;

endmodule : pending_count

// file: trace_element_gen.sv
// Program trace element generator for a speculating core
//
// Behaviour
// - Start emits info, on, context, address first
// - Taken branch emits one taken atom
// - Not-taken branch emits not-taken atom
// - Non-branch instructions emit nothing
// - Core cancel emits cancel with withdrawn count
// - Cancel of untraced work emits nothing
// - Exception emits type and first unexecuted address
// - Commit emits count of oldest resolved elements
`timescale 1ns/100ps
module trace_element_gen (
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire trace_pkg::core_event_t ev_i,
	input  wire logic                   ev_valid_i,
	output logic                        ev_ready_o,
	output trace_pkg::trace_elem_t      elem_o,
	output logic                        elem_valid_o,
	input  wire logic                   elem_ready_i,
	output logic [trace_pkg::CNT_W-1:0] pending_o
);

	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_INFO,
		ST_ON,
		ST_CTX,
		ST_ADDR,
		ST_RUN
	} state_t;

	// Smaller of request and outstanding count
	function automatic logic [trace_pkg::CNT_W-1:0] clamp(
		input logic [trace_pkg::CNT_W-1:0] req,
		input logic [trace_pkg::CNT_W-1:0] pend
	);
		clamp = (req > pend) ? pend : req;
	endfunction : clamp

	state_t                        state_reg;
	state_t                        state_next;
	trace_pkg::trace_elem_t        elem_reg;
	trace_pkg::trace_elem_t        elem_next;
	logic                          valid_reg;
	logic                          valid_next;
	logic [trace_pkg::ADDR_W-1:0]  start_addr_reg;
	logic [trace_pkg::CTX_W-1:0]   start_ctx_reg;
	logic [trace_pkg::CNT_W-1:0]   pending;
	logic [trace_pkg::CNT_W-1:0]   cancel_n;
	logic [trace_pkg::CNT_W-1:0]   commit_n;
	logic [trace_pkg::CNT_W-1:0]   dec_n;
	logic                          out_free;
	logic                          accept;
	logic                          run_acc;
	logic                          is_start;
	logic                          acc_branch;
	logic                          acc_exc;
	logic                          acc_cancel;
	logic                          acc_commit;
	logic                          in_seq;
	logic                          emit_seq;
	logic                          load;

	// =====================================================
	// Event acceptance
	// =====================================================
	assign out_free   = !valid_reg || elem_ready_i;
	assign ev_ready_o = out_free && (state_reg == ST_IDLE || state_reg == ST_RUN);
	assign accept     = ev_valid_i && ev_ready_o;
	assign run_acc    = accept && (state_reg == ST_RUN);
	assign is_start   = accept && (ev_i.op == trace_pkg::OP_START);
	assign acc_branch = run_acc && (ev_i.op == trace_pkg::OP_BRANCH);
	assign acc_exc    = run_acc && (ev_i.op == trace_pkg::OP_EXCEPTION);
	assign acc_cancel = run_acc && (ev_i.op == trace_pkg::OP_CANCEL);
	assign acc_commit = run_acc && (ev_i.op == trace_pkg::OP_COMMIT);
	assign cancel_n   = clamp(ev_i.count, pending);
	assign commit_n   = clamp(ev_i.count, pending);
	assign in_seq     = (state_reg == ST_INFO) || (state_reg == ST_ON)
		|| (state_reg == ST_CTX) || (state_reg == ST_ADDR);
	assign emit_seq   = in_seq && out_free;
	assign load       = emit_seq || acc_branch || acc_exc
		|| (acc_cancel && cancel_n != trace_pkg::CNT_ZERO)
		|| (acc_commit && commit_n != trace_pkg::CNT_ZERO);

	// =====================================================
	// Outstanding element tracking
	// =====================================================
	// count up on atoms and exceptions, down on resolution
	assign dec_n = acc_cancel ? cancel_n : (acc_commit ? commit_n : trace_pkg::CNT_ZERO);

	pending_count #(
		.CW (trace_pkg::CNT_W)
	) u_pending (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.clear_i (is_start),
		.inc_i   (acc_branch || acc_exc),
		.dec_i   (dec_n),
		.count_o (pending)
	);

	// =====================================================
	// Sequencer
	// =====================================================
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE,
			ST_RUN:
			begin
				if (is_start)
					state_next = ST_INFO;
			end
			ST_INFO: if (out_free) state_next = ST_ON;
			ST_ON:   if (out_free) state_next = ST_CTX;
			ST_CTX:  if (out_free) state_next = ST_ADDR;
			ST_ADDR: if (out_free) state_next = ST_RUN;
		endcase
	end

	// =====================================================
	// Element selection
	// =====================================================
	always_comb
	begin
		elem_next = elem_reg;
		elem_next.taken = 1'b0;
		elem_next.count = trace_pkg::CNT_ZERO;
		if (emit_seq)
		begin
			unique case (state_reg)
				ST_INFO: elem_next.kind = trace_pkg::EK_INFO;
				ST_ON:   elem_next.kind = trace_pkg::EK_TRACE_ON;
				ST_CTX:
				begin
					elem_next.kind = trace_pkg::EK_CONTEXT;
					elem_next.addr = start_ctx_reg;
				end
				default:
				begin
					elem_next.kind = trace_pkg::EK_ADDRESS;
					elem_next.addr = start_addr_reg;
				end
			endcase
		end
		else if (acc_branch)
		begin
			elem_next.kind  = trace_pkg::EK_ATOM;
			elem_next.taken = ev_i.taken;
			elem_next.addr  = ev_i.addr;
		end
		else if (acc_exc)
		begin
			elem_next.kind     = trace_pkg::EK_EXCEPTION;
			elem_next.exc_type = ev_i.exc_type;
			elem_next.addr     = ev_i.addr;
		end
		else if (acc_cancel)
		begin
			elem_next.kind  = trace_pkg::EK_CANCEL;
			elem_next.count = cancel_n;
		end
		else if (acc_commit)
		begin
			elem_next.kind  = trace_pkg::EK_COMMIT;
			elem_next.count = commit_n;
		end
	end

	assign valid_next = load ? 1'b1 : (elem_ready_i ? 1'b0 : valid_reg);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_reg      <= ST_IDLE;
			valid_reg      <= 1'b0;
			elem_reg       <= '0;
			start_addr_reg <= '0;
			start_ctx_reg  <= '0;
		end
		else
		begin
			state_reg <= state_next;
			valid_reg <= valid_next;
			if (load)
				elem_reg <= elem_next;
			if (is_start)
			begin
				start_addr_reg <= ev_i.addr;
				start_ctx_reg  <= ev_i.ctx;
			end
		end
	end

	assign elem_o       = elem_reg;
	assign elem_valid_o = valid_reg;
	assign pending_o    = pending;

	// =====================================================
	// Checks
	// =====================================================
	a_start_info_first: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(state_reg == ST_ON && $past(state_reg) == ST_INFO)
		|-> (valid_reg && elem_reg.kind == trace_pkg::EK_INFO))
		else $error("trace info not emitted first");

	a_start_addr_last: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(state_reg == ST_RUN && $past(state_reg) == ST_ADDR)
		|-> (elem_reg.kind == trace_pkg::EK_ADDRESS && elem_reg.addr == start_addr_reg))
		else $error("start address element wrong");

	a_taken_atom: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(acc_branch && ev_i.taken)
		|=> (valid_reg && elem_reg.kind == trace_pkg::EK_ATOM && elem_reg.taken))
		else $error("taken atom missing");

	a_not_taken_atom: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(acc_branch && !ev_i.taken)
		|=> (valid_reg && elem_reg.kind == trace_pkg::EK_ATOM && !elem_reg.taken))
		else $error("not-taken atom missing");

	a_plain_silent: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(run_acc && ev_i.op == trace_pkg::OP_PLAIN) |=> !valid_reg)
		else $error("plain instruction produced element");

	a_cancel_count: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(acc_cancel && pending != trace_pkg::CNT_ZERO && ev_i.count != trace_pkg::CNT_ZERO)
		|=> (valid_reg && elem_reg.kind == trace_pkg::EK_CANCEL
			&& elem_reg.count == clamp($past(ev_i.count), $past(pending))
			&& pending == $past(pending) - elem_reg.count))
		else $error("cancel count wrong");

	a_cancel_untraced: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(acc_cancel && pending == trace_pkg::CNT_ZERO) |=> !valid_reg)
		else $error("cancel of untraced work emitted");

	a_exception_addr: assert property (
		@(posedge clk_i) disable iff (rst_i)
		acc_exc |=> (valid_reg && elem_reg.kind == trace_pkg::EK_EXCEPTION
			&& elem_reg.addr == $past(ev_i.addr) && elem_reg.exc_type == $past(ev_i.exc_type)))
		else $error("exception element wrong");

	a_commit_count: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(acc_commit && pending != trace_pkg::CNT_ZERO && ev_i.count != trace_pkg::CNT_ZERO)
		|=> (elem_reg.kind == trace_pkg::EK_COMMIT
			&& elem_reg.count == clamp($past(ev_i.count), $past(pending))))
		else $error("commit count wrong");

	a_pending_grows: assert property (
		@(posedge clk_i) disable iff (rst_i)
		((acc_branch || acc_exc) && pending != {trace_pkg::CNT_W{1'b1}})
		|=> pending == $past(pending) + trace_pkg::CNT_ONE)
		else $error("outstanding count not incremented");

endmodule : trace_element_gen

// file: core_model.sv
// Behavioural processor core offering events to the trace unit
`timescale 1ns/100ps
module core_model (
	input  wire logic              clk_i,
	input  wire logic              ev_ready_i,
	output trace_pkg::core_event_t ev_o,
	output logic                   ev_valid_o
);
	initial
	begin
		ev_o = '0;
		ev_valid_o = 1'b0;
	end

	// ========
	// Offer one event, hold it until taken or 50 cycles pass, then scramble the bus
	task automatic send(input trace_pkg::core_op_t op, input logic tk,
		input logic [31:0] a, input logic [7:0] c, output logic ok);
		int n;
		@(negedge clk_i);
		ev_o = '{op, tk, c, a, ~a, c};
		ev_valid_o = 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ev_ready_i !== 1'b1 && n < 50);
		ok = (ev_ready_i === 1'b1);
		@(negedge clk_i);
		ev_valid_o = 1'b0;
		ev_o = ~ev_o;
	endtask : send
endmodule : core_model

// file: tb.sv
// Self-checking testbench of the trace element generator
`timescale 1ns/100ps
module tb;
	logic                   clk_i;
	logic                   rst_i;
	trace_pkg::core_event_t ev;
	logic                   ev_valid;
	logic                   ev_ready;
	trace_pkg::trace_elem_t elem;
	logic                   elem_valid;
	logic                   elem_ready;
	logic [7:0]             pending;
	trace_pkg::trace_elem_t got_q[$];
	trace_pkg::trace_elem_t spec_q[$];
	int                     err_total;
	int                     checked;
	logic                   ok;

	trace_element_gen u_dut (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.ev_i        (ev),
		.ev_valid_i  (ev_valid),
		.ev_ready_o  (ev_ready),
		.elem_o      (elem),
		.elem_valid_o(elem_valid),
		.elem_ready_i(elem_ready),
		.pending_o   (pending)
	);

	core_model u_core (
		.clk_i     (clk_i),
		.ev_ready_i(ev_ready),
		.ev_o      (ev),
		.ev_valid_o(ev_valid)
	);

	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	// ========
	// Analyzer side: collect elements, keep the speculative list
	always @(posedge clk_i)
	begin
		if (elem_valid === 1'b1 && elem_ready === 1'b1)
		begin
			got_q.push_back(elem);
			// withdrawn elements dropped from newest end
			if (elem.kind == trace_pkg::EK_CANCEL)
				for (int i = 0; i < int'(elem.count) && spec_q.size() > 0; i++)
					void'(spec_q.pop_back());
			else if (elem.kind == trace_pkg::EK_COMMIT)
				for (int i = 0; i < int'(elem.count) && spec_q.size() > 0; i++)
					void'(spec_q.pop_front());
			else if (elem.kind == trace_pkg::EK_INFO)
				spec_q.delete();
			else if (elem.kind == trace_pkg::EK_ATOM || elem.kind == trace_pkg::EK_EXCEPTION)
				spec_q.push_back(elem);
		end
	end

	task automatic cmp(input string w, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (e !== g)
		begin
			err_total++;
			$display("FAIL %s expected %h seen %h", w, e, g);
		end
	endtask : cmp

	task automatic send(input trace_pkg::core_op_t op, input logic tk,
		input logic [31:0] a, input logic [7:0] c);
		u_core.send(op, tk, a, c, ok);
		cmp("event taken", 32'h1, {31'h0, ok});
	endtask : send

	// Wait for n elements, then a few cycles for strays
	task automatic drain(input int n);
		for (int i = 0; i < 20 && got_q.size() < n; i++)
			@(negedge clk_i);
		repeat (3) @(negedge clk_i);
		cmp("element count", n, got_q.size());
	endtask : drain

	task automatic pop(input trace_pkg::elem_kind_t k, input logic tk,
		input logic [31:0] a, input logic [7:0] c, input logic ua);
		trace_pkg::trace_elem_t e;
		if (got_q.size() == 0)
		begin
			cmp("element present", 32'h1, 32'h0);
			return;
		end
		e = got_q.pop_front();
		cmp("kind", 32'(k), 32'(e.kind));
		cmp("taken", 32'(tk), 32'(e.taken));
		if (ua)
			cmp("address", a, e.addr);
		if (k == trace_pkg::EK_EXCEPTION)
			cmp("exception type", 32'(c), 32'(e.exc_type));
		else
			cmp("count", 32'(c), 32'(e.count));
	endtask : pop

	// ========
	// Scenarios
	task automatic t_start();
		send(trace_pkg::OP_START, 1'b0, 32'h0000_1000, 8'h00);
		drain(4);
		pop(trace_pkg::EK_INFO, 1'b0, 32'h0, 8'h00, 1'b0);
		pop(trace_pkg::EK_TRACE_ON, 1'b0, 32'h0, 8'h00, 1'b0);
		pop(trace_pkg::EK_CONTEXT, 1'b0, ~32'h0000_1000, 8'h00, 1'b1);
		pop(trace_pkg::EK_ADDRESS, 1'b0, 32'h0000_1000, 8'h00, 1'b1);
		cmp("pending", 32'h0, 32'(pending));
	endtask : t_start

	task automatic t_branches();
		send(trace_pkg::OP_BRANCH, 1'b1, 32'h0000_2000, 8'h00);
		for (int i = 0; i < 3; i++)
			send(trace_pkg::OP_PLAIN, 1'b0, 32'h0000_2000 + 4 * i, 8'h00);
		send(trace_pkg::OP_NONE, 1'b0, 32'h0, 8'h00);
		send(trace_pkg::OP_BRANCH, 1'b0, 32'h0000_3000, 8'h00);
		send(trace_pkg::OP_PLAIN, 1'b0, 32'h0000_2010, 8'h00);
		drain(2);
		pop(trace_pkg::EK_ATOM, 1'b1, 32'h0000_2000, 8'h00, 1'b1);
		pop(trace_pkg::EK_ATOM, 1'b0, 32'h0000_3000, 8'h00, 1'b1);
		cmp("pending", 32'h2, 32'(pending));
	endtask : t_branches

	task automatic t_cancel();
		send(trace_pkg::OP_CANCEL, 1'b0, 32'h0, 8'h01);
		drain(1);
		pop(trace_pkg::EK_CANCEL, 1'b0, 32'h0, 8'h01, 1'b0);
		cmp("pending", 32'h1, 32'(pending));
		cmp("analyzer kept", 32'h1, 32'(spec_q.size()));
		cmp("kept atom taken", 32'h1, 32'(spec_q[0].taken));
	endtask : t_cancel

	// Exception element held while the analyzer stalls
	task automatic t_exception_stall();
		elem_ready = 1'b0;
		send(trace_pkg::OP_EXCEPTION, 1'b0, 32'h0000_2000, 8'h12);
		repeat (3) @(negedge clk_i);
		cmp("held valid", 32'h1, 32'(elem_valid));
		cmp("ready in stall", 32'h0, 32'(ev_ready));
		elem_ready = 1'b1;
		drain(1);
		pop(trace_pkg::EK_EXCEPTION, 1'b0, 32'h0000_2000, 8'h12, 1'b1);
		cmp("pending", 32'h2, 32'(pending));
	endtask : t_exception_stall

	task automatic t_commit();
		send(trace_pkg::OP_COMMIT, 1'b0, 32'h0, 8'hFF);
		drain(1);
		pop(trace_pkg::EK_COMMIT, 1'b0, 32'h0, 8'h02, 1'b0);
		cmp("pending", 32'h0, 32'(pending));
		cmp("analyzer list", 32'h0, 32'(spec_q.size()));
	endtask : t_commit

	task automatic t_cancel_untraced();
		send(trace_pkg::OP_CANCEL, 1'b0, 32'h0, 8'h04);
		drain(0);
		cmp("pending", 32'h0, 32'(pending));
	endtask : t_cancel_untraced

	// Restart while tracing clears the outstanding count
	task automatic t_restart();
		send(trace_pkg::OP_BRANCH, 1'b1, 32'h0000_5000, 8'h00);
		send(trace_pkg::OP_START, 1'b0, 32'h0000_4000, 8'h00);
		drain(5);
		pop(trace_pkg::EK_ATOM, 1'b1, 32'h0000_5000, 8'h00, 1'b1);
		pop(trace_pkg::EK_INFO, 1'b0, 32'h0, 8'h00, 1'b0);
		pop(trace_pkg::EK_TRACE_ON, 1'b0, 32'h0, 8'h00, 1'b0);
		pop(trace_pkg::EK_CONTEXT, 1'b0, ~32'h0000_4000, 8'h00, 1'b1);
		pop(trace_pkg::EK_ADDRESS, 1'b0, 32'h0000_4000, 8'h00, 1'b1);
		cmp("pending", 32'h0, 32'(pending));
		cmp("analyzer list", 32'h0, 32'(spec_q.size()));
	endtask : t_restart

	// Reset in mid-run: events before a start give no element
	task automatic t_reset_idle();
		rst_i = 1'b1;
		repeat (3) @(negedge clk_i);
		rst_i = 1'b0;
		send(trace_pkg::OP_BRANCH, 1'b1, 32'h0000_6000, 8'h00);
		drain(0);
		cmp("pending", 32'h0, 32'(pending));
		cmp("valid after reset", 32'h0, 32'(elem_valid));
	endtask : t_reset_idle

	task automatic end_of_test();
		$display("Comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test

	// ========
	// Main sequence
	initial
	begin
		err_total = 0;
		checked = 0;
		rst_i = 1'b1;
		elem_ready = 1'b1;
		repeat (3) @(negedge clk_i);
		rst_i = 1'b0;
		t_start();
		t_branches();
		t_cancel();
		t_exception_stall();
		t_commit();
		t_cancel_untraced();
		t_restart();
		t_reset_idle();
		end_of_test();
	end

	// Watchdog at 5000 cycles, well beyond the fewer than 100 cycles of the tests
	initial
	begin
		#100000;
		err_total++;
		end_of_test();
	end
endmodule : tb
